// File: core/lphy_pkg.sv
package lphy_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] OFS_PORT_LINE_DATA  = 3'h0;
  localparam logic [2:0] OFS_PHY_CONTROL     = 3'h1;
  localparam logic [2:0] OFS_FACTORY_TEST_A  = 3'h2;
  localparam logic [2:0] OFS_SLEW_TIMEOUT    = 3'h3;
  localparam logic [2:0] OFS_FACTORY_TEST_B  = 3'h4;
  localparam logic [2:0] OFS_PHY_STATUS      = 3'h5;
  localparam logic [2:0] OFS_IRQ_ENABLE      = 3'h6;
  localparam logic [2:0] OFS_IRQ_FLAGS       = 3'h7;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_TX_DRIVE     = 1;
  localparam int BIT_RX_LEVEL     = 0;
  localparam int BIT_PHY_ENABLE   = 3;
  localparam int BIT_LISTEN_ONLY  = 2;
  localparam int BIT_WAKEUP_EN    = 1;
  localparam int BIT_STRONG_PU    = 0;
  localparam int BIT_DT_DISABLE   = 7;
  localparam int BIT_SLEW_HI      = 1;
  localparam int BIT_SLEW_LO      = 0;
  localparam int BIT_DT_STATUS    = 7;
  localparam int BIT_DT_EVENT     = 7;
  localparam int BIT_OC_EVENT     = 6;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic       RST_TX_DRIVE = 1'h1;
  localparam logic [3:0] RST_CONTROL  = 4'h0;
  localparam logic [7:0] RST_TEST     = 8'h00;
  localparam logic       RST_DT_DIS   = 1'h0;
  localparam logic [1:0] RST_SLEW     = 2'h0;
  localparam logic [1:0] RST_IRQ      = 2'h0;
  localparam logic [7:0] RD_ZERO      = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LPHY_SHUTDOWN,
    LPHY_NORMAL,
    LPHY_LISTEN,
    LPHY_STANDBY
  } lphy_mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lphy_bus_req_t;

  typedef struct packed {
    logic phy_enable_bit;
    logic listen_only_bit;
    logic wakeup_enable_bit;
    logic strong_pullup_select;
  } lphy_ctrl_t;

  typedef struct packed {
    logic [1:0] slew_select;
    logic       dominant_timeout_disable;
    logic       strong_pullup_on;
    logic       wakeup_armed;
  } lphy_phy_cfg_t;

endpackage : lphy_pkg

// File: core/lphy_regs.sv
// Behaviour
// (R1) Block decodes only the register offset; base is added at chip level.
// (R2) Bit 1 of port_line_data drives the transceiver transmit input.
// (R3) Bit 0 of port_line_data reads the live receive output; writes ignored.
// (R4) port_line_data and phy_control are readable and writable any time.
// (R5) phy_enable_bit set leaves shutdown; cleared enters shutdown.
// (R6) In shutdown only the weak pullup holds the bus recessive.
// (R7) All registers stay accessible during shutdown.
// (R8) listen_only_bit selects receive-only operation when set.
// (R9) wakeup_enable_bit enables bus wake-up during standby.
// (R10) strong_pullup_select requests the stronger pullup; cleared means weak only.
// (R11) No strong pullup in shutdown or in standby with wake-up disabled.
// (R12) factory_test_a always readable, writable only in special mode.
// (R13) Software should not write the factory test bits.
// (R14) Transmit input used only in normal mode, ignored otherwise.
// (R15) In standby receive output is off except wake-up pulses when enabled.
// (R16) Timeout-disable and slew fields writable only while in shutdown.
// (R17) Writing one clears an interrupt flag; writing zero leaves it.
// (R18) Unimplemented bits read zero and ignore writes.
// (R19) Enabled and not standby: normal if listen_only clear, else receive-only.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module lphy_regs
  import lphy_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // Register port
  input  wire logic [2:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output var  logic [7:0]    reg_rdata,
  // Chip level
  input  wire logic          special_mode,
  input  wire logic          chip_standby,
  // Transceiver front end
  input  wire logic          phy_rx_output,
  input  wire logic          wake_pulse,
  input  wire logic          dominant_timeout_event,
  input  wire logic          dominant_timeout_level,
  input  wire logic          overcurrent_event,
  output var  logic          phy_tx_input,
  output var  logic          rx_to_serial,
  output var  lphy_mode_t    phy_mode,
  output var  lphy_phy_cfg_t phy_cfg,
  output var  logic [7:0]    factory_test_a,
  output var  logic [7:0]    factory_test_b,
  // Interrupt
  output var  logic          irq
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic          tx_drive_bit;
    lphy_ctrl_t    ctrl;
    logic [7:0]    test_a;
    logic [7:0]    test_b;
    logic          dt_dis;
    logic [1:0]    slew;
    logic [1:0]    irq_en;
    logic [1:0]    flags;
    logic [7:0]    rdata;
    logic          tx_out;
    logic          rx_out;
    lphy_mode_t    mode;
    lphy_phy_cfg_t cfg;
    logic          irq;
  } lphy_state_t;

  lphy_state_t   st;
  lphy_state_t   next_st;
  lphy_bus_req_t req;
  lphy_mode_t    mode_now;
  logic          strong_now;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  always_comb begin
    if (!st.ctrl.phy_enable_bit) begin
      mode_now = LPHY_SHUTDOWN; // R5
    end else if (chip_standby) begin
      mode_now = LPHY_STANDBY;
    end else if (st.ctrl.listen_only_bit) begin
      mode_now = LPHY_LISTEN; // R8 R19
    end else begin
      mode_now = LPHY_NORMAL; // R19
    end
    // Weak pullup only unless enabled and not in a dead standby
    strong_now = st.ctrl.strong_pullup_select & st.ctrl.phy_enable_bit
               & ~(chip_standby & ~st.ctrl.wakeup_enable_bit); // R6 R10 R11
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (req.wr) begin // R1 R7
      case (req.addr)
        OFS_PORT_LINE_DATA: begin
          next_st.tx_drive_bit = req.wdata[BIT_TX_DRIVE]; // R2 R3 R4
        end
        OFS_PHY_CONTROL: begin
          next_st.ctrl = lphy_ctrl_t'(req.wdata[3:0]); // R4 R18
        end
        OFS_FACTORY_TEST_A: begin
          if (special_mode) begin
            next_st.test_a = req.wdata; // R12
          end
        end
        OFS_SLEW_TIMEOUT: begin
          if (!st.ctrl.phy_enable_bit) begin
            next_st.dt_dis = req.wdata[BIT_DT_DISABLE]; // R16
            next_st.slew   = req.wdata[BIT_SLEW_HI:BIT_SLEW_LO]; // R16
          end
        end
        OFS_FACTORY_TEST_B: begin
          if (special_mode) begin
            next_st.test_b = req.wdata;
          end
        end
        OFS_IRQ_ENABLE: begin
          next_st.irq_en = req.wdata[BIT_DT_EVENT:BIT_OC_EVENT];
        end
        OFS_IRQ_FLAGS: begin
          next_st.flags = st.flags & ~req.wdata[BIT_DT_EVENT:BIT_OC_EVENT]; // R17
        end
        default: begin
          next_st.flags = st.flags;
        end
      endcase
    end
    // Events set after the clear so a same-cycle event wins
    if (dominant_timeout_event || dominant_timeout_level) begin
      next_st.flags[1] = 1'b1;
    end
    if (overcurrent_event) begin
      next_st.flags[0] = 1'b1;
    end

    next_st.rdata = RD_ZERO;
    if (req.rd) begin
      case (req.addr)
        OFS_PORT_LINE_DATA: begin
          next_st.rdata[BIT_TX_DRIVE] = st.tx_drive_bit;
          next_st.rdata[BIT_RX_LEVEL] = phy_rx_output; // R3
        end
        OFS_PHY_CONTROL: begin
          next_st.rdata[3:0] = st.ctrl; // R18
        end
        OFS_FACTORY_TEST_A: begin
          next_st.rdata = st.test_a; // R12
        end
        OFS_SLEW_TIMEOUT: begin
          next_st.rdata[BIT_DT_DISABLE]          = st.dt_dis;
          next_st.rdata[BIT_SLEW_HI:BIT_SLEW_LO] = st.slew;
        end
        OFS_FACTORY_TEST_B: begin
          next_st.rdata = st.test_b;
        end
        OFS_PHY_STATUS: begin
          next_st.rdata[BIT_DT_STATUS] = dominant_timeout_level;
        end
        OFS_IRQ_ENABLE: begin
          next_st.rdata[BIT_DT_EVENT:BIT_OC_EVENT] = st.irq_en;
        end
        OFS_IRQ_FLAGS: begin
          next_st.rdata[BIT_DT_EVENT:BIT_OC_EVENT] = st.flags;
        end
        default: begin
          next_st.rdata = RD_ZERO;
        end
      endcase
    end

    // Transceiver side
    next_st.mode   = mode_now;
    next_st.tx_out = (mode_now == LPHY_NORMAL) ? st.tx_drive_bit : 1'b1; // R14
    if (mode_now == LPHY_STANDBY) begin
      next_st.rx_out = ~(st.ctrl.wakeup_enable_bit & wake_pulse); // R15
    end else begin
      next_st.rx_out = phy_rx_output;
    end
    next_st.cfg.slew_select              = st.slew;
    next_st.cfg.dominant_timeout_disable = st.dt_dis;
    next_st.cfg.strong_pullup_on         = strong_now; // R11
    next_st.cfg.wakeup_armed             = st.ctrl.wakeup_enable_bit
                                         & (mode_now == LPHY_STANDBY); // R9
    next_st.irq = |(st.flags & st.irq_en);
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st.tx_drive_bit <= RST_TX_DRIVE;
      st.ctrl         <= lphy_ctrl_t'(RST_CONTROL);
      st.test_a       <= RST_TEST;
      st.test_b       <= RST_TEST;
      st.dt_dis       <= RST_DT_DIS;
      st.slew         <= RST_SLEW;
      st.irq_en       <= RST_IRQ;
      st.flags        <= RST_IRQ;
      st.rdata        <= RD_ZERO;
      st.tx_out       <= 1'b1;
      st.rx_out       <= 1'b1;
      st.mode         <= LPHY_SHUTDOWN;
      st.cfg          <= '0;
      st.irq          <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata      = st.rdata;
  assign phy_tx_input   = st.tx_out;
  assign rx_to_serial   = st.rx_out;
  assign phy_mode       = st.mode;
  assign phy_cfg        = st.cfg;
  assign factory_test_a = st.test_a;
  assign factory_test_b = st.test_b;
  assign irq            = st.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_ctrl_write(logic [3:0] v);
    reg_wr && reg_addr == OFS_PHY_CONTROL && reg_wdata[3:0] == v;
  endsequence

  sequence s_ctrl_read;
    reg_rd && reg_addr == OFS_PHY_CONTROL;
  endsequence

  AST_CTRL_READBACK: assert property ( // R4
    s_ctrl_write(4'h5) ##1 s_ctrl_read |=> reg_rdata == 8'h05)
    else $error("control readback differs");

  AST_RX_BIT_LIVE: assert property ( // R3
    reg_rd && reg_addr == OFS_PORT_LINE_DATA
    |=> reg_rdata[BIT_RX_LEVEL] == $past(phy_rx_output))
    else $error("receive bit not live");

  AST_UNUSED_ZERO: assert property ( // R18
    reg_rd && reg_addr == OFS_PORT_LINE_DATA |=> reg_rdata[7:2] == 6'h00)
    else $error("unimplemented bits not zero");

  AST_SHUTDOWN_MODE: assert property ( // R5
    !st.ctrl.phy_enable_bit |=> phy_mode == LPHY_SHUTDOWN)
    else $error("shutdown not reported");

  AST_NO_STRONG_PU: assert property ( // R11
    (!st.ctrl.phy_enable_bit || (chip_standby && !st.ctrl.wakeup_enable_bit))
    |=> !phy_cfg.strong_pullup_on)
    else $error("strong pullup in forbidden mode");

  AST_TX_IGNORED: assert property ( // R14
    phy_mode != LPHY_NORMAL && $past(phy_mode) != LPHY_NORMAL |-> phy_tx_input)
    else $error("transmit used outside normal");

  AST_TEST_A_LOCK: assert property ( // R12
    reg_wr && reg_addr == OFS_FACTORY_TEST_A && !special_mode
    |=> $stable(factory_test_a))
    else $error("test register written outside special mode");

  AST_SLEW_LOCK: assert property ( // R16
    reg_wr && reg_addr == OFS_SLEW_TIMEOUT && st.ctrl.phy_enable_bit
    |=> $stable(phy_cfg.slew_select) [*2])
    else $error("slew changed while enabled");

  AST_FLAG_W1C: assert property ( // R17
    reg_wr && reg_addr == OFS_IRQ_FLAGS && reg_wdata[BIT_OC_EVENT]
    && !overcurrent_event |=> !st.flags[0])
    else $error("flag not cleared by one");

  AST_IRQ_LEVEL: assert property ( // R17
    (st.flags & st.irq_en) != 2'h0 |=> irq)
    else $error("interrupt not raised");

  AST_LISTEN_MODE: assert property ( // R8
    st.ctrl.phy_enable_bit && !chip_standby && st.ctrl.listen_only_bit
    |=> phy_mode == LPHY_LISTEN)
    else $error("listen mode not reported");

  AST_NORMAL_MODE: assert property ( // R19
    st.ctrl.phy_enable_bit && !chip_standby && !st.ctrl.listen_only_bit
    |=> phy_mode == LPHY_NORMAL)
    else $error("normal mode not reported");

  AST_STANDBY_MODE: assert property ( // R19
    st.ctrl.phy_enable_bit && chip_standby |=> phy_mode == LPHY_STANDBY)
    else $error("standby not reported");

  AST_TX_SHUTDOWN: assert property ( // R6
    !st.ctrl.phy_enable_bit |=> phy_tx_input)
    else $error("transmit not recessive in shutdown");

  AST_TX_DRIVE_NORMAL: assert property ( // R2
    phy_mode == LPHY_NORMAL |-> phy_tx_input == $past(st.tx_drive_bit))
    else $error("transmit does not follow drive bit");

  AST_WAKE_ARMED: assert property ( // R9
    st.ctrl.phy_enable_bit && chip_standby && st.ctrl.wakeup_enable_bit
    |=> phy_cfg.wakeup_armed)
    else $error("wake-up not armed in standby");

  AST_WAKE_IDLE: assert property ( // R9
    !(st.ctrl.phy_enable_bit && chip_standby && st.ctrl.wakeup_enable_bit)
    |=> !phy_cfg.wakeup_armed)
    else $error("wake-up armed outside enabled standby");

  AST_STRONG_PU_ON: assert property ( // R10
    st.ctrl.strong_pullup_select && st.ctrl.phy_enable_bit
    && !(chip_standby && !st.ctrl.wakeup_enable_bit) |=> phy_cfg.strong_pullup_on)
    else $error("strong pullup not granted");

  AST_WEAK_ONLY: assert property ( // R10
    !st.ctrl.strong_pullup_select |=> !phy_cfg.strong_pullup_on)
    else $error("strong pullup without select");

  AST_RX_STANDBY_IDLE: assert property ( // R15
    st.ctrl.phy_enable_bit && chip_standby
    && !(st.ctrl.wakeup_enable_bit && wake_pulse) |=> rx_to_serial)
    else $error("receive output active in standby");

  AST_RX_WAKE_PULSE: assert property ( // R15
    st.ctrl.phy_enable_bit && chip_standby && st.ctrl.wakeup_enable_bit
    && wake_pulse |=> !rx_to_serial)
    else $error("wake-up pulse not passed on");

  AST_RX_FOLLOWS: assert property ( // R15
    !(st.ctrl.phy_enable_bit && chip_standby)
    |=> rx_to_serial == $past(phy_rx_output))
    else $error("receive output does not follow line");

  AST_DT_DIS_LOCK: assert property ( // R16
    reg_wr && reg_addr == OFS_SLEW_TIMEOUT && st.ctrl.phy_enable_bit
    |=> $stable(phy_cfg.dominant_timeout_disable) [*2])
    else $error("timeout disable changed while enabled");

  AST_FLAG_SET_WINS: assert property ( // R17
    reg_wr && reg_addr == OFS_IRQ_FLAGS
    && (dominant_timeout_event || dominant_timeout_level) |=> st.flags[1])
    else $error("timeout flag lost to a clear");

  AST_FLAG_KEEP: assert property ( // R17
    reg_wr && reg_addr == OFS_IRQ_FLAGS && !reg_wdata[BIT_OC_EVENT]
    && st.flags[0] |=> st.flags[0])
    else $error("flag cleared by a zero");

  AST_STATUS_ZERO: assert property ( // R18
    reg_rd && reg_addr == OFS_PHY_STATUS |=> reg_rdata[6:0] == 7'h00)
    else $error("status unused bits not zero");

  AST_IRQ_LOW: assert property ( // R17
    (st.flags & st.irq_en) == 2'h0 |=> !irq)
    else $error("interrupt raised without cause");

endmodule : lphy_regs

`default_nettype wire

// File: bench/lphy_front_model.sv
`timescale 1ns/1ps
`default_nettype none

module lphy_front_model
  import lphy_pkg::*;
(
  // From register bank
  input  wire logic       phy_tx_input,
  input  wire lphy_mode_t phy_mode,
  // Bench requests: 0 wake, 1 timeout event, 2 timeout level, 3 overcurrent
  input  wire logic       remote_dominant,
  input  wire logic [3:0] fire,
  // To register bank
  output var  logic       phy_rx_output,
  output var  logic       wake_pulse,
  output var  logic       dominant_timeout_event,
  output var  logic       dominant_timeout_level,
  output var  logic       overcurrent_event
);
  // Wired-and bus, recessive high through the pullup
  always_comb begin
    phy_rx_output          = !(remote_dominant || (phy_mode == LPHY_NORMAL && !phy_tx_input));
    wake_pulse             = fire[0];
    dominant_timeout_event = fire[1];
    dominant_timeout_level = fire[2];
    overcurrent_event      = fire[3];
  end
endmodule : lphy_front_model

`default_nettype wire

// File: bench/lin_phy_control_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none

module lin_phy_control_registers_bench
  import lphy_pkg::*;
;
  logic          mclk, rst_b, reg_wr, reg_rd, special_mode, chip_standby, remote_dominant;
  logic [2:0]    reg_addr;
  logic [7:0]    reg_wdata, reg_rdata, factory_test_a, factory_test_b, rv;
  logic [3:0]    fire;
  logic          phy_rx_output, wake_pulse, dominant_timeout_event, dominant_timeout_level;
  logic          overcurrent_event, phy_tx_input, rx_to_serial, irq;
  lphy_mode_t    phy_mode;
  lphy_phy_cfg_t phy_cfg;
  int            mismatches, comparisons;

  lphy_regs i_dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .special_mode, .chip_standby, .phy_rx_output, .wake_pulse, .dominant_timeout_event,
    .dominant_timeout_level, .overcurrent_event, .phy_tx_input, .rx_to_serial, .phy_mode,
    .phy_cfg, .factory_test_a, .factory_test_b, .irq);

  lphy_front_model i_front (.phy_tx_input, .phy_mode, .remote_dominant, .fire,
    .phy_rx_output, .wake_pulse, .dominant_timeout_event, .dominant_timeout_level,
    .overcurrent_event);

  always #2 mclk = ~mclk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rdchk

  // Write then read back to back, no idle cycle between the strobes
  task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : wr_rd

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic fire_ev(input int b);
    @(posedge mclk);
    fire[b] <= 1'b1;
    @(posedge mclk);
    fire[b] <= 1'b0;
  endtask : fire_ev

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rdchk(3'(i), (i == 0) ? 8'h03 : 8'h00);
    end
    chk(8'(phy_mode), 8'(LPHY_SHUTDOWN));
  endtask : t_reset

  task automatic t_modes();
    wr(3'h1, 8'h08);
    settle();
    chk(8'(phy_mode), 8'(LPHY_NORMAL));
    wr(3'h0, 8'h00);
    settle();
    chk({7'h0, phy_tx_input}, 8'h00);
    rdchk(3'h0, 8'h00);
    wr(3'h1, 8'h0c);
    settle();
    chk(8'(phy_mode), 8'(LPHY_LISTEN));
    chk({7'h0, phy_tx_input}, 8'h01);
    @(posedge mclk);
    chip_standby <= 1'b1;
    wr(3'h1, 8'h09);
    settle();
    chk(8'(phy_mode), 8'(LPHY_STANDBY));
    chk({7'h0, phy_cfg.strong_pullup_on}, 8'h00);
    wr(3'h1, 8'h0b);
    settle();
    chk({6'h0, phy_cfg.strong_pullup_on, phy_cfg.wakeup_armed}, 8'h03);
    fire_ev(0);
    #1 chk({7'h0, rx_to_serial}, 8'h00);
    settle();
    chk({7'h0, rx_to_serial}, 8'h01);
    @(posedge mclk);
    chip_standby <= 1'b0;
    wr(3'h1, 8'h01);
    settle();
    chk({7'h0, phy_cfg.strong_pullup_on}, 8'h00);
    rdchk(3'h1, 8'h01);
    wr(3'h0, 8'hff);
    rdchk(3'h0, 8'h03);
    @(posedge mclk);
    remote_dominant <= 1'b1;
    settle();
    rdchk(3'h0, 8'h02);
    @(posedge mclk);
    remote_dominant <= 1'b0;
  endtask : t_modes

  task automatic t_slew();
    wr_rd(3'h1, 8'h05, 8'h05);
    wr(3'h3, 8'hfe);
    rdchk(3'h3, 8'h82);
    chk({phy_cfg.dominant_timeout_disable, 5'h0, phy_cfg.slew_select}, 8'h82);
    wr(3'h1, 8'h08);
    wr(3'h3, 8'h01);
    rdchk(3'h3, 8'h82);
    wr(3'h1, 8'h00);
  endtask : t_slew

  task automatic t_test();
    for (int i = 2; i <= 4; i += 2) begin
      special_mode <= 1'b0;
      wr(3'(i), 8'h5a);
      rdchk(3'(i), 8'h00);
      @(posedge mclk);
      special_mode <= 1'b1;
      wr(3'(i), 8'ha5);
      rdchk(3'(i), 8'ha5);
      chk((i == 2) ? factory_test_a : factory_test_b, 8'ha5);
      wr(3'(i), 8'h00);
    end
    special_mode <= 1'b0;
  endtask : t_test

  task automatic t_irq();
    wr(3'h6, 8'hff);
    rdchk(3'h6, 8'hc0);
    fire_ev(3);
    settle();
    chk({7'h0, irq}, 8'h01);
    wr(3'h7, 8'h00);
    rdchk(3'h7, 8'h40);
    wr(3'h7, 8'h40);
    rdchk(3'h7, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(3'h6, 8'h80);
    fire_ev(3);
    settle();
    chk({7'h0, irq}, 8'h00);
    wr(3'h7, 8'h40);
    @(posedge mclk);
    fire[2] <= 1'b1;
    fire_ev(1);
    settle();
    rdchk(3'h5, 8'h80);
    chk({7'h0, irq}, 8'h01);
    wr(3'h7, 8'h80);
    rdchk(3'h7, 8'h80);
    @(posedge mclk);
    fire[2] <= 1'b0;
    wr(3'h7, 8'h80);
    rdchk(3'h7, 8'h00);
    rdchk(3'h5, 8'h00);
  endtask : t_irq

  // ------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {mclk, rst_b, reg_wr, reg_rd, special_mode, chip_standby, remote_dominant} = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    fire      = '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_modes();
    t_slew();
    t_test();
    t_irq();
    stop_test();
  end

  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule : lin_phy_control_registers_bench

`default_nettype wire
